/* sleep_wake_pkg.sv */
// package for the sleep and wake controller: wake indices, state and timing
// assumes a single 100 MHz clock and software control through plain ports
package sleep_wake_pkg;

	localparam int CLK_HZ = 100000000;
	localparam int LP_CLK_HZ = 32768;
	// always-on tick divider, rounded down to whole cycles
	localparam int LP_DIV = CLK_HZ / LP_CLK_HZ;
	localparam int LP_DIV_W = 12;

	// wake vector layout
	localparam int WAKE_W = 73;
	localparam int WAKE_PCIE = 1;
	localparam int WAKE_BT = 8;
	localparam int WAKE_WIFI = 9;
	localparam int WAKE_AUDIO = 12;
	localparam int WAKE_DISPLAY0_HOTPLUG = 19;
	localparam int WAKE_CEC = 20;
	localparam int WAKE_DISPLAY1_HOTPLUG = 21;
	localparam int WAKE_CAMERA_VERTICAL_SYNC = 23;
	localparam int WAKE_POWER_BUTTON_N = 29;
	localparam int WAKE_MOTION = 46;
	localparam int WAKE_CAN_PORT1_ERROR = 47;
	localparam int WAKE_CAN_WAKE = 48;
	localparam int WAKE_CAN_PORT0_ERROR = 49;
	localparam int WAKE_TOUCH = 51;
	localparam int WAKE_VBUS = 53;
	localparam int WAKE_EXP0 = 54;
	localparam int WAKE_MODEM = 55;
	localparam int WAKE_BATTERY_LOW_N = 56;
	localparam int WAKE_EXP1 = 58;
	localparam int WAKE_VBUS_EN0 = 61;
	localparam int WAKE_VBUS_EN1 = 62;
	localparam int WAKE_LIGHT = 63;
	localparam int WAKE_COLDBOOT = 64;
	localparam int WAKE_RECOVERY = 67;
	localparam int WAKE_SLEEP_PIN = 68;
	// internal sources (timer and thermal); vdd low and card come from pins
	localparam int WAKE_TIMER = 69;
	localparam int WAKE_THERMAL = 70;
	localparam int WAKE_VDD_LOW = 71;
	localparam int WAKE_CARD = 72;

	localparam logic [WAKE_W-1:0] WAKE_RESET = '0;
	localparam int TIMER_W = 16;
	localparam int TEMP_W = 8;

	typedef enum logic [1:0] {ST_OFF, ST_ON, ST_SLEEP} power_state_e;

	// connector and module pins as they arrive, not yet synchronised
	typedef struct packed {
		logic power_button_n;
		logic system_wake_n;
		logic recovery_strap_n;
		logic sleep_request_n;
		logic pcie_wake_request_n;
		logic bt_wake_input;
		logic wifi_wake_input;
		logic audio_codec_irq;
		logic display0_hotplug;
		logic display1_hotplug;
		logic consumer_control_line;
		logic camera_vertical_sync;
		logic motion_sensor_irq;
		logic can_port0_error;
		logic can_port1_error;
		logic can_wake_input;
		logic touch_irq;
		logic usb_vbus_sense;
		logic expander0_irq;
		logic expander1_irq;
		logic modem_wake_input;
		logic battery_low_n;
		logic usb_vbus_enable0;
		logic usb_vbus_enable1;
		logic light_proximity_irq;
		logic modem_coldboot_line;
		logic vdd_in_low;
		logic card_detect_n;
	} wake_pins_s;

endpackage : sleep_wake_pkg

/* sleep_wake_controller.sv */
// sleep-state and wake-event logic: off/on/sleep, output hold, wake sources
// assumes pins arrive asynchronously; software bits come from the same clock
`timescale 1ns/1ps

module sleep_wake_controller
	import sleep_wake_pkg::*;
#(
	parameter int PAD_W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// software control
	input wire logic swSleepReq,
	input wire logic swOffReq,
	input wire logic [WAKE_W-1:0] wakeEnable,
	input wire logic [WAKE_W-1:0] pendingClear,
	input wire logic [TIMER_W-1:0] wakeTimerLoad,
	input wire logic wakeTimerArm,
	input wire logic [TEMP_W-1:0] hotLimit,
	input wire logic [TEMP_W-1:0] coldLimit,
	input wire logic [TEMP_W-1:0] temperature,
	// pins
	input wire wake_pins_s pins,
	input wire logic [PAD_W-1:0] padLive,
	// status and pads
	output power_state_e powerState,
	output logic [WAKE_W-1:0] wakePending,
	output logic wakeEvent,
	output logic btHostInfo,
	output logic lpTick,
	output logic [PAD_W-1:0] padOut
);

	////////////////////////////////////////////////////////////////////////////
	// always-on tick and pin synchronisers

	logic [LP_DIV_W-1:0] divCount_reg, divCount_next;
	logic lpTick_reg, lpTick_next;
	logic [WAKE_W-1:0] rawWake;
	logic [WAKE_W-1:0] syncA_reg, syncA_next;
	logic [WAKE_W-1:0] syncB_reg, syncB_next;
	logic [WAKE_W-1:0] syncC_reg, syncC_next;
	logic [WAKE_W-1:0] stableWake, heldWake_reg;

	always_comb begin
		rawWake = '0;
		rawWake[WAKE_PCIE] = ~pins.pcie_wake_request_n;
		rawWake[WAKE_BT] = pins.bt_wake_input;
		rawWake[WAKE_WIFI] = pins.wifi_wake_input;
		rawWake[WAKE_AUDIO] = pins.audio_codec_irq;
		rawWake[WAKE_CEC] = pins.consumer_control_line;
		rawWake[WAKE_DISPLAY0_HOTPLUG] = pins.display0_hotplug;
		rawWake[WAKE_DISPLAY1_HOTPLUG] = pins.display1_hotplug;
		rawWake[WAKE_CAMERA_VERTICAL_SYNC] = pins.camera_vertical_sync;
		// either active-low input counts as a button press
		rawWake[WAKE_POWER_BUTTON_N] = ~pins.power_button_n | ~pins.system_wake_n;
		rawWake[WAKE_RECOVERY] = ~pins.recovery_strap_n;
		rawWake[WAKE_SLEEP_PIN] = ~pins.sleep_request_n;
		rawWake[WAKE_MOTION] = pins.motion_sensor_irq;
		rawWake[WAKE_CAN_PORT1_ERROR] = pins.can_port1_error;
		rawWake[WAKE_CAN_WAKE] = pins.can_wake_input;
		rawWake[WAKE_CAN_PORT0_ERROR] = pins.can_port0_error;
		rawWake[WAKE_TOUCH] = pins.touch_irq;
		rawWake[WAKE_VBUS] = pins.usb_vbus_sense;
		rawWake[WAKE_EXP0] = pins.expander0_irq;
		rawWake[WAKE_MODEM] = pins.modem_wake_input;
		rawWake[WAKE_BATTERY_LOW_N] = ~pins.battery_low_n;
		rawWake[WAKE_EXP1] = pins.expander1_irq;
		rawWake[WAKE_VBUS_EN0] = pins.usb_vbus_enable0;
		rawWake[WAKE_VBUS_EN1] = pins.usb_vbus_enable1;
		rawWake[WAKE_LIGHT] = pins.light_proximity_irq;
		rawWake[WAKE_COLDBOOT] = pins.modem_coldboot_line;
		rawWake[WAKE_VDD_LOW] = pins.vdd_in_low;
		rawWake[WAKE_CARD] = ~pins.card_detect_n;
	end

	always_comb begin
		lpTick_next = 1'b0;
		divCount_next = divCount_reg + 12'h001;
		if (divCount_reg == LP_DIV_W'(LP_DIV - 1)) begin
			divCount_next = '0;
			lpTick_next = 1'b1;
		end
		syncA_next = syncA_reg;
		syncB_next = syncB_reg;
		syncC_next = syncC_reg;
		// sampling only on the slow tick filters glitches shorter than a tick
		if (lpTick_reg) begin
			syncA_next = rawWake;
			syncB_next = syncA_reg;
			syncC_next = syncB_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			divCount_reg <= '0;
			lpTick_reg <= 1'b0;
			syncA_reg <= '0;
			syncB_reg <= '0;
			syncC_reg <= '0;
			heldWake_reg <= '0;
		end else begin
			divCount_reg <= divCount_next;
			lpTick_reg <= lpTick_next;
			syncA_reg <= syncA_next;
			syncB_reg <= syncB_next;
			syncC_reg <= syncC_next;
			heldWake_reg <= stableWake;
		end
	end

	// a change counts only once the second and third stage agree; else last level holds
	assign stableWake = (syncC_reg & ~(syncB_reg ^ syncC_reg))
		| (heldWake_reg & (syncB_reg ^ syncC_reg));

	////////////////////////////////////////////////////////////////////////////
	// power state, wake timer and pending flags

	power_state_e state_reg, state_next;
	logic [TIMER_W-1:0] timer_reg, timer_next;
	logic timerArmed_reg, timerArmed_next;
	logic [WAKE_W-1:0] pending_reg, pending_next;
	logic [WAKE_W-1:0] wakeSet;
	logic wakeEvent_reg, wakeEvent_next;
	logic btInfo_reg, btInfo_next;
	logic pressed_reg, pressed_next;
	logic timerExpire;
	logic thermalTrip;
	logic wakeNow;

	always_comb begin
		timerExpire = (state_reg == ST_SLEEP) && timerArmed_reg && lpTick_reg
			&& (timer_reg == 16'h0001);
		thermalTrip = (temperature > hotLimit) || (temperature < coldLimit);
		wakeSet = '0;
		if (state_reg == ST_SLEEP) begin
			// on-state pin levels are info only, not latched
			if (lpTick_reg) begin
				wakeSet = stableWake;
			end
			wakeSet[WAKE_TIMER] = timerExpire;
			wakeSet[WAKE_THERMAL] = thermalTrip;
		end
		// set wins over a clear in the same cycle
		pending_next = (pending_reg & ~pendingClear) | wakeSet;
		wakeNow = |(pending_reg & wakeEnable);
		btInfo_next = (state_reg == ST_ON) ? stableWake[WAKE_BT] : 1'b0;
		pressed_next = lpTick_reg ? stableWake[WAKE_POWER_BUTTON_N] : pressed_reg;
		state_next = state_reg;
		timer_next = timer_reg;
		timerArmed_next = timerArmed_reg;
		wakeEvent_next = 1'b0;
		unique case (state_reg)
			ST_OFF: begin
				// button release after a press powers on
				if (pressed_reg && !pressed_next) begin
					state_next = ST_ON;
				end
			end
			ST_ON: begin
				if (swOffReq) begin
					state_next = ST_OFF;
				end else if (swSleepReq) begin
					state_next = ST_SLEEP;
					timer_next = wakeTimerLoad;
					timerArmed_next = wakeTimerArm && (wakeTimerLoad != '0);
				end
			end
			ST_SLEEP: begin
				if (timerArmed_reg && lpTick_reg) begin
					timer_next = timer_reg - 16'h0001;
					if (timerExpire) begin
						timerArmed_next = 1'b0;
					end
				end
				if (wakeNow) begin
					state_next = ST_ON;
					wakeEvent_next = 1'b1;
					timerArmed_next = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_OFF;
			timer_reg <= '0;
			timerArmed_reg <= 1'b0;
			pending_reg <= WAKE_RESET;
			wakeEvent_reg <= 1'b0;
			btInfo_reg <= 1'b0;
			pressed_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			timerArmed_reg <= timerArmed_next;
			pending_reg <= pending_next;
			wakeEvent_reg <= wakeEvent_next;
			btInfo_reg <= btInfo_next;
			pressed_reg <= pressed_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output pads

	logic [PAD_W-1:0] pad_reg, pad_next;

	always_comb begin
		pad_next = '0;
		if (state_reg == ST_ON) begin
			pad_next = padLive;
		end else if (state_reg == ST_SLEEP) begin
			pad_next = pad_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pad_reg <= '0;
		end else begin
			pad_reg <= pad_next;
		end
	end

	assign powerState = state_reg;
	assign wakePending = pending_reg;
	assign wakeEvent = wakeEvent_reg;
	assign btHostInfo = btInfo_reg;
	assign lpTick = lpTick_reg;
	assign padOut = pad_reg;

	////////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_sleepEntry;
		state_reg == ST_ON && !swOffReq && swSleepReq;
	endsequence

	sequence s_armedEntry;
		s_sleepEntry ##0 wakeTimerArm && wakeTimerLoad != '0;
	endsequence

	property p_sleep_only_from_on;
		@(posedge clk) disable iff (rst)
		(state_reg == ST_SLEEP && $past(state_reg) != ST_SLEEP)
			|-> $past(state_reg) == ST_ON && $past(swSleepReq);
	endproperty
	a_sleep_only_from_on: assert property (p_sleep_only_from_on) else $error("bad sleep entry");

	property p_pad_hold;
		@(posedge clk) disable iff (rst)
		(state_reg == ST_SLEEP) ##1 (state_reg == ST_SLEEP) |-> padOut == $past(padOut);
	endproperty
	a_pad_hold: assert property (p_pad_hold) else $error("pads moved in sleep");

	property p_wake_exit;
		@(posedge clk) disable iff (rst)
		(state_reg == ST_SLEEP && |(pending_reg & wakeEnable))
			|=> state_reg == ST_ON && wakeEvent_reg;
	endproperty
	a_wake_exit: assert property (p_wake_exit) else $error("wake not taken");

	property p_no_spurious_wake;
		@(posedge clk) disable iff (rst)
		(state_reg == ST_SLEEP && !(|(pending_reg & wakeEnable))) |=> state_reg == ST_SLEEP;
	endproperty
	a_no_spurious_wake: assert property (p_no_spurious_wake) else $error("woke with nothing pending");

	property p_timer_load;
		@(posedge clk) disable iff (rst)
		s_armedEntry |=> timerArmed_reg && timer_reg == $past(wakeTimerLoad);
	endproperty
	a_timer_load: assert property (p_timer_load) else $error("timer not loaded");

	property p_timer_expire;
		@(posedge clk) disable iff (rst)
		(state_reg == ST_SLEEP && timerArmed_reg && lpTick_reg && timer_reg == 16'h0001)
			|=> pending_reg[WAKE_TIMER] && !timerArmed_reg;
	endproperty
	a_timer_expire: assert property (p_timer_expire) else $error("timer expiry lost");

	property p_thermal;
		@(posedge clk) disable iff (rst)
		(state_reg == ST_SLEEP && (temperature > hotLimit || temperature < coldLimit))
			|=> pending_reg[WAKE_THERMAL];
	endproperty
	a_thermal: assert property (p_thermal) else $error("thermal wake lost");

	property p_sources_latch;
		@(posedge clk) disable iff (rst)
		(state_reg == ST_SLEEP && lpTick_reg && syncB_reg[WAKE_VBUS] && syncC_reg[WAKE_VBUS]
			&& syncB_reg[WAKE_CARD] && syncC_reg[WAKE_CARD])
			|=> pending_reg[WAKE_VBUS] && pending_reg[WAKE_CARD];
	endproperty
	a_sources_latch: assert property (p_sources_latch) else $error("vbus or card lost");

	property p_bt_info_on;
		@(posedge clk) disable iff (rst)
		(state_reg == ST_ON && !pending_reg[WAKE_BT]) |=> !pending_reg[WAKE_BT];
	endproperty
	a_bt_info_on: assert property (p_bt_info_on) else $error("bt latched while on");

	property p_tick_spacing;
		@(posedge clk) disable iff (rst)
		lpTick_reg |=> !lpTick_reg [*8];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("tick too fast");

endmodule : sleep_wake_controller

/* wake_pin_model.sv */
// carrier-board peripherals driving the module's wake pins
// assumes the bench names the asserted sources; polarity is applied here
`timescale 1ns/1ps

module wake_pin_model
	import sleep_wake_pkg::*;
(
	// requests from the bench
	input wire logic [27:0] assertMask,
	input wire logic btRxData,
	// pins toward the module
	output wake_pins_s pins
);

	// active-low pins rest high through their pull-ups
	localparam logic [27:0] ACTIVE_LOW = 28'hf800041;

	logic [27:0] asserted;

	always_comb begin
		asserted = assertMask;
		asserted[22] = assertMask[22] | btRxData;
	end

	assign pins = wake_pins_s'(asserted ^ ACTIVE_LOW);

endmodule : wake_pin_model

/* testbench.sv */
// self-checking bench for the sleep and wake controller
// assumes wake_pin_model as the carrier side; inputs change on falling edges
`timescale 1ns/1ps

module testbench;
	import sleep_wake_pkg::*;

	localparam int LIMIT = 99000;
	// wake index of each pin, most significant struct field first
	localparam int IDX [28] = '{29, 29, 67, 68, 1, 8, 9, 12, 19, 21, 20, 23, 46, 49,
		47, 48, 51, 53, 54, 58, 55, 56, 61, 62, 63, 64, 71, 72};

	logic clk, rst, swSleepReq, swOffReq, wakeTimerArm, btRxData;
	logic [WAKE_W-1:0] wakeEnable, pendingClear, wakePending;
	logic [TIMER_W-1:0] wakeTimerLoad;
	logic [TEMP_W-1:0] hotLimit, coldLimit, temperature;
	logic [27:0] assertMask;
	logic [31:0] padLive, padOut, padHeld;
	wake_pins_s pins;
	power_state_e powerState;
	logic wakeEvent, btHostInfo, lpTick;
	int n_mismatch = 0;
	int n_compared = 0;
	int seed = 86;

	sleep_wake_controller i_sleep_wake_controller (.clk(clk), .rst(rst),
		.swSleepReq(swSleepReq), .swOffReq(swOffReq), .wakeEnable(wakeEnable),
		.pendingClear(pendingClear), .wakeTimerLoad(wakeTimerLoad),
		.wakeTimerArm(wakeTimerArm), .hotLimit(hotLimit), .coldLimit(coldLimit),
		.temperature(temperature), .pins(pins), .padLive(padLive),
		.powerState(powerState), .wakePending(wakePending), .wakeEvent(wakeEvent),
		.btHostInfo(btHostInfo), .lpTick(lpTick), .padOut(padOut));

	wake_pin_model i_wake_pin_model (.assertMask(assertMask), .btRxData(btRxData), .pins(pins));

	////////////////////////////////////////////////////////////////////////////

	task automatic fail(input string what);
		n_mismatch++;
		$display("Error at %0t: %s", $time, what);
	endtask : fail

	task automatic chkState(input power_state_e got, input power_state_e exp);
		n_compared++;
		if (got !== exp) fail("power state differs");
	endtask : chkState

	task automatic chkWake(input logic [WAKE_W-1:0] got, input logic [WAKE_W-1:0] exp);
		n_compared++;
		if (got !== exp) fail("wake vector differs");
	endtask : chkWake

	task automatic chkBit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) fail("flag differs");
	endtask : chkBit

	task automatic chkPad(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) fail("pad levels differ");
	endtask : chkPad

	task automatic chkCount(input int got, input int exp);
		n_compared++;
		if (got != exp) fail("cycle count differs");
	endtask : chkCount

	function automatic logic [WAKE_W-1:0] expMask(input logic [27:0] m);
		logic [WAKE_W-1:0] e;
		e = '0;
		for (int i = 0; i < 28; i++)
			if (m[27-i])
				e[IDX[i]] = 1'b1;
		return e;
	endfunction : expMask

	task automatic waitFor(input logic onState, input int lim);
		int k;
		k = 0;
		while (k < lim && (onState ? powerState !== ST_ON : wakeEvent !== 1'b1)) begin
			@(negedge clk);
			k++;
		end
	endtask : waitFor

	task automatic enterSleep(input logic [WAKE_W-1:0] en);
		wakeEnable = en;
		padHeld = $random(seed);
		padLive = padHeld;
		swSleepReq = 1'b1;
		@(negedge clk);
		swSleepReq = 1'b0;
		padLive = ~padHeld;
		chkState(powerState, ST_SLEEP);
	endtask : enterSleep

	task automatic clearPending;
		pendingClear = '1;
		@(negedge clk);
		pendingClear = '0;
		@(negedge clk);
		chkWake(wakePending, '0);
	endtask : clearPending

	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////////

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// hang guard, above the expected run of about 82k cycles
	initial begin
		repeat (LIMIT) @(posedge clk);
		n_mismatch++;
		summarize();
	end

	initial begin
		int k;
		logic [27:0] m;
		logic [WAKE_W-1:0] exp;
		rst = 1'b1;
		swSleepReq = 1'b0;
		swOffReq = 1'b0;
		wakeEnable = '0;
		pendingClear = '0;
		wakeTimerLoad = '0;
		wakeTimerArm = 1'b0;
		hotLimit = 8'hc0 | (8'($random(seed)) & 8'h0f);
		coldLimit = 8'h20 | (8'($random(seed)) & 8'h0f);
		temperature = 8'h64;
		assertMask = '0;
		btRxData = 1'b0;
		padLive = '0;
		padHeld = '0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		chkState(powerState, ST_OFF);
		chkPad(padOut, '0);
		// always-on tick spacing
		k = 0;
		while (lpTick !== 1'b1 && k < 4000) begin
			@(negedge clk);
			k++;
		end
		@(negedge clk);
		k = 1;
		while (lpTick !== 1'b1 && k < 4000) begin
			@(negedge clk);
			k++;
		end
		chkCount(k, LP_DIV);
		// power on: ON follows the release, not the press
		assertMask[26] = 1'b1;
		repeat (4 * LP_DIV) @(negedge clk);
		chkState(powerState, ST_OFF);
		assertMask = '0;
		waitFor(1'b1, 5 * LP_DIV);
		chkState(powerState, ST_ON);
		// random pin sets; round 1 has only thermal enabled
		for (int r = 0; r < 3; r++) begin
			m = 28'($random(seed));
			btRxData = 1'($random(seed));
			if (m == '0)
				m[5] = 1'b1;
			assertMask = m;
			m[22] = m[22] | btRxData;
			exp = expMask(m);
			repeat (4 * LP_DIV) @(negedge clk);
			chkState(powerState, ST_ON);
			chkBit(btHostInfo, m[22]);
			enterSleep(r == 1 ? (WAKE_W'(1) << WAKE_THERMAL) : '1);
			if (r == 1) begin
				repeat (2 * LP_DIV) @(negedge clk);
				chkState(powerState, ST_SLEEP);
				chkPad(padOut, padHeld);
				chkBit(btHostInfo, 1'b0);
				temperature = hotLimit + 8'h01;
				exp[WAKE_THERMAL] = 1'b1;
			end
			waitFor(1'b0, 4 * LP_DIV);
			chkBit(wakeEvent, 1'b1);
			chkState(powerState, ST_ON);
			chkWake(WAKE_W'(wakePending[36:0]), WAKE_W'(exp[36:0]));
			chkWake(wakePending >> 37, exp >> 37);
			temperature = 8'h64;
			@(negedge clk);
			chkPad(padOut, ~padHeld);
			clearPending();
		end
		// wake timer, then the cold limit
		wakeTimerLoad = 16'h0002;
		wakeTimerArm = 1'b1;
		enterSleep(WAKE_W'(1) << WAKE_TIMER);
		waitFor(1'b0, 3 * LP_DIV + 10);
		chkBit(wakePending[WAKE_TIMER], 1'b1);
		chkState(powerState, ST_ON);
		clearPending();
		wakeTimerArm = 1'b0;
		temperature = coldLimit - 8'h01;
		enterSleep(WAKE_W'(1) << WAKE_THERMAL);
		waitFor(1'b0, 8);
		chkBit(wakePending[WAKE_THERMAL], 1'b1);
		temperature = 8'h64;
		clearPending();
		// shutdown beats sleep, and OFF ignores sleep requests
		swSleepReq = 1'b1;
		swOffReq = 1'b1;
		@(negedge clk);
		swOffReq = 1'b0;
		repeat (3) @(negedge clk);
		chkState(powerState, ST_OFF);
		chkPad(padOut, '0);
		swSleepReq = 1'b0;
		summarize();
	end

endmodule : testbench
